// ---- src/lrc_pkg.sv ----
// lrc_pkg: constants and carrier types for the ladder reference control block.
// assumes a 32-bit AXI4-Lite register bus; registers sit at four times their index.

package lrc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // register indexes; byte address is four times the index
    localparam logic [ADDR_W-1:0] CTRL_INDEX = 12'h09F;
    localparam logic [ADDR_W-1:0] DIR_INDEX = 12'h085;
    localparam logic [ADDR_W-1:0] STATUS_INDEX = 12'h0A0;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_INDEX[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] DIR_ADDR = {DIR_INDEX[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_INDEX[ADDR_W-3:0], 2'b00};

    ////////////////////////////////////////////////////////////////////////////////
    // field positions and values after reset
    localparam int unsigned POWER_BIT = 7;
    localparam int unsigned ROUTE_BIT = 6;
    localparam int unsigned RANGE_BIT = 5;
    localparam int unsigned RSVD_BIT = 4;
    localparam int unsigned REF_PIN_DIR_BIT = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hEF;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam int unsigned TAP_COUNT = 16;

    // status register fields
    localparam int unsigned STAT_POWER_BIT = 0;
    localparam int unsigned STAT_ROUTE_BIT = 1;
    localparam int unsigned STAT_RANGE_BIT = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // control register layout
    typedef struct packed {
        logic power_en;
        logic route_en;
        logic range_low;
        logic rsvd;
        logic [3:0] tap;
    } lrc_ctrl_type;

endpackage

// ---- src/lrc_tap_decode.sv ----
// lrc_tap_decode: registered one-hot tap switch drive for the resistor ladder.
// assumes the control word arrives from a register on the same clock.
`timescale 1ns/1ps

module lrc_tap_decode #(
    parameter int unsigned TAPS = lrc_pkg::TAP_COUNT
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control word
    input wire lrc_pkg::lrc_ctrl_type ctrl,
    // ladder switch drive
    output logic [TAPS-1:0] tap_onehot,
    output logic range_low
);

    logic [TAPS-1:0] tap_ff;
    logic [TAPS-1:0] nxt_tap;
    logic range_ff;
    logic nxt_range;

    function automatic logic [TAPS-1:0] onehot(input logic [3:0] idx);
        logic [TAPS-1:0] v;
        v = '0;
        v[idx] = 1'b1;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // all switches open while powered down, so the ladder carries no tap load
    always_comb begin
        nxt_tap = ctrl.power_en ? onehot(ctrl.tap) : '0;
        nxt_range = ctrl.range_low;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tap_ff <= '0;
            range_ff <= 1'b0;
        end else begin
            tap_ff <= nxt_tap;
            range_ff <= nxt_range;
        end
    end

    assign tap_onehot = tap_ff;
    assign range_low = range_ff;

endmodule

// ---- src/lrc_top.sv ----
// lrc_top: register slave and control logic of the ladder voltage reference.
// assumes an AXI4-Lite master on aclk; the analog ladder consumes the outputs.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps

module lrc_top #(
    parameter int unsigned TAPS = lrc_pkg::TAP_COUNT
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [lrc_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [lrc_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [lrc_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [lrc_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // ladder drive
    output logic ladder_power_enable,
    output logic ladder_range_low,
    output logic [TAPS-1:0] ladder_tap_select,
    output logic reference_output_pin_route
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    lrc_pkg::lrc_ctrl_type ctrl_ff;
    lrc_pkg::lrc_ctrl_type nxt_ctrl;
    logic [7:0] dir_ff;
    logic [7:0] nxt_dir;
    logic power_ff;
    logic nxt_power;
    logic route_ff;
    logic nxt_route;

    logic aw_held_ff;
    logic nxt_aw_held;
    logic [lrc_pkg::ADDR_W-1:0] waddr_ff;
    logic [lrc_pkg::ADDR_W-1:0] nxt_waddr;
    logic w_held_ff;
    logic nxt_w_held;
    logic [7:0] wbyte_ff;
    logic [7:0] nxt_wbyte;
    logic wlane_ff;
    logic nxt_wlane;
    logic awready_ff;
    logic nxt_awready;
    logic wready_ff;
    logic nxt_wready;
    logic bvalid_ff;
    logic nxt_bvalid;
    logic [1:0] bresp_ff;
    logic [1:0] nxt_bresp;

    logic arready_ff;
    logic nxt_arready;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic [lrc_pkg::DATA_W-1:0] rdata_ff;
    logic [lrc_pkg::DATA_W-1:0] nxt_rdata;
    logic [1:0] rresp_ff;
    logic [1:0] nxt_rresp;

    logic do_write;

    function automatic logic is_mapped(input logic [lrc_pkg::ADDR_W-1:0] a);
        return (a == lrc_pkg::CTRL_ADDR) || (a == lrc_pkg::DIR_ADDR) || (a == lrc_pkg::STATUS_ADDR);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // write path: address and data are taken in either order, then committed together

    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_waddr = waddr_ff;
        nxt_w_held = w_held_ff;
        nxt_wbyte = wbyte_ff;
        nxt_wlane = wlane_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_ctrl = ctrl_ff;
        nxt_dir = dir_ff;
        if (awvalid && awready_ff) begin
            nxt_aw_held = 1'b1;
            nxt_waddr = {awaddr[lrc_pkg::ADDR_W-1:2], 2'b00};
        end
        if (wvalid && wready_ff) begin
            nxt_w_held = 1'b1;
            nxt_wbyte = wdata[7:0];
            nxt_wlane = wstrb[0];
        end
        if (bvalid_ff && bready) begin
            nxt_bvalid = 1'b0;
        end
        if (do_write) begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = is_mapped(waddr_ff) ? lrc_pkg::RESP_OKAY : lrc_pkg::RESP_SLVERR;
            // only byte lane 0 carries register bits; other lanes are dropped
            if (wlane_ff && waddr_ff == lrc_pkg::CTRL_ADDR) begin
                nxt_ctrl = lrc_pkg::lrc_ctrl_type'(wbyte_ff & lrc_pkg::CTRL_WRITE_MASK);
            end
            if (wlane_ff && waddr_ff == lrc_pkg::DIR_ADDR) begin
                nxt_dir = wbyte_ff;
            end
        end
        // one write at a time: a channel reopens only once the response is gone
        nxt_awready = !nxt_aw_held && !nxt_bvalid;
        nxt_wready = !nxt_w_held && !nxt_bvalid;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path: one cycle from address to data

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && rready) begin
            nxt_rvalid = 1'b0;
        end
        if (arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = '0;
            nxt_rresp = lrc_pkg::RESP_OKAY;
            case ({araddr[lrc_pkg::ADDR_W-1:2], 2'b00})
                lrc_pkg::CTRL_ADDR: begin
                    nxt_rdata[7:0] = ctrl_ff & lrc_pkg::CTRL_WRITE_MASK;
                end
                lrc_pkg::DIR_ADDR: begin
                    nxt_rdata[7:0] = dir_ff;
                end
                lrc_pkg::STATUS_ADDR: begin
                    nxt_rdata[lrc_pkg::STAT_POWER_BIT] = power_ff;
                    nxt_rdata[lrc_pkg::STAT_ROUTE_BIT] = route_ff;
                    nxt_rdata[lrc_pkg::STAT_RANGE_BIT] = ctrl_ff.range_low;
                end
                default: begin
                    nxt_rresp = lrc_pkg::RESP_SLVERR;
                end
            endcase
        end
        nxt_arready = !nxt_rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ladder control: nothing but bus writes and reset touch the control word, so
    // sleep, wake sources and comparator mode changes cannot disturb it

    always_comb begin
        nxt_power = ctrl_ff.power_en;
        // both the pin direction bit and the route enable must be set
        nxt_route = dir_ff[lrc_pkg::REF_PIN_DIR_BIT] && ctrl_ff.route_en;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // every reset clears the whole control word; there is no sleep-wake path here
            ctrl_ff <= lrc_pkg::lrc_ctrl_type'(lrc_pkg::CTRL_RESET);
            dir_ff <= lrc_pkg::DIR_RESET;
            power_ff <= 1'b0;
            route_ff <= 1'b0;
            aw_held_ff <= 1'b0;
            waddr_ff <= '0;
            w_held_ff <= 1'b0;
            wbyte_ff <= 8'h00;
            wlane_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= lrc_pkg::RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= lrc_pkg::RESP_OKAY;
        end else begin
            ctrl_ff <= nxt_ctrl;
            dir_ff <= nxt_dir;
            power_ff <= nxt_power;
            route_ff <= nxt_route;
            aw_held_ff <= nxt_aw_held;
            waddr_ff <= nxt_waddr;
            w_held_ff <= nxt_w_held;
            wbyte_ff <= nxt_wbyte;
            wlane_ff <= nxt_wlane;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // tap switch drive

    lrc_tap_decode #(
        .TAPS(TAPS)
    ) u_tap_decode (
        .aclk(aclk),
        .aresetn(aresetn),
        .ctrl(ctrl_ff),
        .tap_onehot(ladder_tap_select),
        .range_low(ladder_range_low)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign ladder_power_enable = power_ff;
    assign reference_output_pin_route = route_ff;

endmodule

// ---- tb/lrc_top_properties.sv ----
// lrc_top_properties: port-level timing checks for the ladder reference control block.
// assumes it is bound into lrc_top and sees only that module's ports.
`timescale 1ns/1ps

module lrc_top_properties #(
    parameter int unsigned TAPS = lrc_pkg::TAP_COUNT
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [lrc_pkg::ADDR_W-1:0] araddr,
    input wire logic rvalid,
    input wire logic [lrc_pkg::DATA_W-1:0] rdata,
    input wire logic bvalid,
    // ladder drive
    input wire logic ladder_power_enable,
    input wire logic ladder_range_low,
    input wire logic [TAPS-1:0] ladder_tap_select,
    input wire logic reference_output_pin_route
);
    ////////////////////////////////////////////////////////////////////////////////
    // remembers whether the read under way targets the control register
    logic rd_ctrl_ff;
    logic nxt_rd_ctrl;
    always_comb begin
        nxt_rd_ctrl = rd_ctrl_ff;
        if (arvalid && arready)
            nxt_rd_ctrl = (araddr[11:2] == lrc_pkg::CTRL_ADDR[11:2]);
    end
    always_ff @(posedge aclk) begin
        rd_ctrl_ff <= aresetn ? nxt_rd_ctrl : 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_off_no_tap; !ladder_power_enable |-> ladder_tap_select == '0; endproperty
    a_off_no_tap: assert property (p_off_no_tap) else $error("tap driven while ladder off");
    property p_one_tap; $onehot0(ladder_tap_select); endproperty
    a_one_tap: assert property (p_one_tap) else $error("more than one tap driven");
    property p_rst_pwr; $rose(aresetn) |-> !ladder_power_enable; endproperty
    a_rst_pwr: assert property (p_rst_pwr) else $error("power on after reset");
    property p_rst_route; $rose(aresetn) |-> !reference_output_pin_route; endproperty
    a_rst_route: assert property (p_rst_route) else $error("pin routed after reset");
    property p_rst_range; $rose(aresetn) |-> !ladder_range_low; endproperty
    a_rst_range: assert property (p_rst_range) else $error("low range after reset");
    property p_rst_tap; $rose(aresetn) |-> ladder_tap_select == '0; endproperty
    a_rst_tap: assert property (p_rst_tap) else $error("tap set after reset");
    // outside reset the ladder may only move as the result of a completed write;
    // a mid-run reset clears the taps with no write, so the edge after it is excluded
    property p_tap_by_write; $changed(ladder_tap_select) && $past(aresetn) |-> $past(bvalid); endproperty
    a_tap_by_write: assert property (p_tap_by_write) else $error("tap moved without write");
    property p_rsvd_zero; rvalid && rd_ctrl_ff |-> rdata[4] == 1'b0; endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");
endmodule

// ---- tb/lrc_top_tb_top.sv ----
// lrc_top_tb_top: directed tests of the ladder reference control block over AXI4-Lite.
// assumes a 40 MHz clock and the port checker bound below.
`timescale 1ns/1ps

bind lrc_top lrc_top_properties #(.TAPS(TAPS)) u_props (.aclk, .aresetn, .arvalid, .arready, .araddr, .rvalid,
    .rdata, .bvalid, .ladder_power_enable, .ladder_range_low, .ladder_tap_select, .reference_output_pin_route);

module lrc_top_tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [lrc_pkg::ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic ladder_power_enable, ladder_range_low, reference_output_pin_route;
    logic [15:0] ladder_tap_select;
    int n_mismatch = 0;
    int samples_checked = 0;

    lrc_top dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .ladder_power_enable, .ladder_range_low, .ladder_tap_select, .reference_output_pin_route);

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // extra edge at the end lets the ladder outputs settle after the commit
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
    endtask
    task automatic out_chk(input logic p, input logic r, input logic o, input logic [15:0] t);
        chk({13'h0000, ladder_power_enable, ladder_range_low, reference_output_pin_route, ladder_tap_select},
            {13'h0000, p, r, o, t});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(lrc_pkg::CTRL_ADDR, 32'h0000_0000, lrc_pkg::RESP_OKAY);
        rd(lrc_pkg::DIR_ADDR, 32'h0000_00FF, lrc_pkg::RESP_OKAY);
        out_chk(1'b0, 1'b0, 1'b0, 16'h0000);
        $display("t_reset done");
    endtask
    task automatic t_taps();
        logic [31:0] d;
        for (int t = 0; t < 16; t++) begin
            d = 32'h80 | (32'(t % 2) << 5) | 32'(t);
            wr(lrc_pkg::CTRL_ADDR, d, 4'hF, lrc_pkg::RESP_OKAY);
            out_chk(1'b1, 1'(t % 2), 1'b0, 16'h0001 << t);
            rd(lrc_pkg::CTRL_ADDR, d, lrc_pkg::RESP_OKAY);
        end
        wr(lrc_pkg::CTRL_ADDR, 32'h2F, 4'hF, lrc_pkg::RESP_OKAY);
        out_chk(1'b0, 1'b1, 1'b0, 16'h0000);
        wr(lrc_pkg::CTRL_ADDR, 32'hFFFF_FFFF, 4'hF, lrc_pkg::RESP_OKAY);
        rd(lrc_pkg::CTRL_ADDR, 32'h0000_00EF, lrc_pkg::RESP_OKAY);
        wr(lrc_pkg::CTRL_ADDR, 32'h0000_0000, 4'h0, lrc_pkg::RESP_OKAY);
        rd(lrc_pkg::CTRL_ADDR, 32'h0000_00EF, lrc_pkg::RESP_OKAY);
        out_chk(1'b1, 1'b1, 1'b1, 16'h8000);
        $display("t_taps done");
    endtask
    task automatic t_route();
        for (int i = 0; i < 4; i++) begin
            wr(lrc_pkg::DIR_ADDR, (i % 2) ? 32'hFF : 32'hFB, 4'hF, lrc_pkg::RESP_OKAY);
            wr(lrc_pkg::CTRL_ADDR, (i / 2) ? 32'hC0 : 32'h80, 4'hF, lrc_pkg::RESP_OKAY);
            out_chk(1'b1, 1'b0, 1'(i == 3), 16'h0001);
        end
        rd(lrc_pkg::STATUS_ADDR, 32'h0000_0003, lrc_pkg::RESP_OKAY);
        rd(12'h000, 32'h0000_0000, lrc_pkg::RESP_SLVERR);
        wr(12'h000, 32'h0000_0080, 4'hF, lrc_pkg::RESP_SLVERR);
        $display("t_route done");
    endtask
    task automatic t_reset_mid();
        wr(lrc_pkg::CTRL_ADDR, 32'hEF, 4'hF, lrc_pkg::RESP_OKAY);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(lrc_pkg::CTRL_ADDR, 32'h0000_0000, lrc_pkg::RESP_OKAY);
        out_chk(1'b0, 1'b0, 1'b0, 16'h0000);
        rd(lrc_pkg::DIR_ADDR, 32'h0000_00FF, lrc_pkg::RESP_OKAY);
        $display("t_reset_mid done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
        {awaddr, araddr, wdata, wstrb} <= '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_taps();
        t_route();
        t_reset_mid();
        tally_and_finish();
    end
    // the tests take well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
